// File: rtl/sdrc_regs.vh
// register map, field layout and timing constants of the spindle run control
`ifndef SDRC_REGS_VH
`define SDRC_REGS_VH
// register byte offsets
`define SDRC_CTRL_OFS 8'h00
`define SDRC_CFG_OFS 8'h04
`define SDRC_SETP_OFS 8'h08
`define SDRC_SPEED_OFS 8'h0C
`define SDRC_ERR_OFS 8'h10
`define SDRC_CHVAL_OFS 8'h14
`define SDRC_STAT_OFS 8'h18
`define SDRC_DISP_OFS 8'h1C
// ctrl fields
`define SDRC_CTRL_SER_START 0
`define SDRC_CTRL_SER_STOP 1
`define SDRC_CTRL_SAFE_STOP 2
`define SDRC_CTRL_AT_SPEED 3
`define SDRC_CTRL_OVERLOAD 4
// cfg fields
`define SDRC_CFG_POL_LSB 0
`define SDRC_CFG_SEL_LSB 3
`define SDRC_CFG_ANA_START 5
`define SDRC_CFG_MINMAX 6
`define SDRC_CFG_DIR_NV 7
`define SDRC_CFG_RESET 32'h0000_0000
// timing: key hold and setup inactivity in ms, debounce in us
`define SDRC_CLK_MHZ 200
`define SDRC_HOLD_MS 4000
`define SDRC_IDLE_MS 5000
`define SDRC_DEB_US 10
`define SDRC_CYC_PER_MS (`SDRC_CLK_MHZ * 1000)
`define SDRC_DEB_CYC (`SDRC_DEB_US * `SDRC_CLK_MHZ)
// error code base shown as E30..E45
`define SDRC_ERR_BASE 8'h1E
`endif

// File: rtl/sdrc_run_control.v
// spindle run control: keys, setup modes, start/stop arbitration, display
`timescale 1ns/1ps
`include "sdrc_regs.vh"
module sdrc_run_control #(
  parameter HOLD_CYC = `SDRC_HOLD_MS * `SDRC_CYC_PER_MS,
  parameter IDLE_CYC = `SDRC_IDLE_MS * `SDRC_CYC_PER_MS,
  parameter DEB_CYC = `SDRC_DEB_CYC,
  parameter ROT_CYC = 200000000,
  parameter NPLACE = 16
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hsel,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  input wire i_key_start,
  input wire i_key_stop,
  input wire [2:0] i_din,
  input wire i_dir_nv,
  output reg o_dir_nv_wr,
  output reg o_dir_nv_val,
  output reg o_run,
  output reg o_dir_ccw,
  output reg [15:0] o_speed_cmd,
  output reg o_relay1,
  output reg o_relay2,
  output reg o_relay3,
  output reg o_led_over,
  output reg [11:0] o_disp,
  output reg o_disp_err
);

  localparam ST_OPER = 3'b001;
  localparam ST_DIR = 3'b010;
  localparam ST_CHAR = 3'b100;
  localparam SRC_NONE = 3'h0;
  localparam SRC_PANEL = 3'h1;
  localparam SRC_DIG = 3'h2;
  localparam SRC_ANA = 3'h3;
  localparam SRC_SER = 3'h4;

  // two-flop synchronisers for keys and digital inputs
  reg [4:0] sy1_r;
  reg [4:0] sy2_r;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sy1_r <= 5'h00;
      sy2_r <= 5'h00;
    end else begin
      sy1_r <= {i_din, i_key_stop, i_key_start};
      sy2_r <= sy1_r;
    end
  end

  // debounce: key state follows input once it holds steady
  reg [1:0] key_r;
  reg [1:0] key_d_r;
  reg [31:0] deb_cnt_r;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      key_r <= 2'h0;
      key_d_r <= 2'h0;
      deb_cnt_r <= 32'h0;
    end else begin
      key_d_r <= key_r;
      if (sy2_r[1:0] == key_r)
        deb_cnt_r <= 32'h0;
      else if (deb_cnt_r >= DEB_CYC - 1) begin
        key_r <= sy2_r[1:0];
        deb_cnt_r <= 32'h0;
      end else
        deb_cnt_r <= deb_cnt_r + 32'h1;
    end
  end
  wire start_press = key_r[0] & ~key_d_r[0];
  wire stop_press = key_r[1] & ~key_d_r[1];
  wire any_press = start_press | stop_press;

  // software registers
  reg [31:0] cfg_r;
  reg [15:0] setp_r;
  reg [15:0] speed_r;
  reg [15:0] err_r;
  reg [15:0] chval_r;
  reg ser_start_r;
  reg ser_stop_r;
  reg safe_r;
  reg at_speed_r;
  reg overload_r;

  // input polarity and start/stop input selection
  function in_active;
    input [2:0] din;
    input [2:0] pol;
    input [1:0] sel;
    reg [2:0] lv;
    begin
      lv = din ^ ~pol;
      in_active = (sel == 2'h3) ? lv[0] : lv[sel];
    end
  endfunction
  wire dig_on = in_active(sy2_r[4:2], cfg_r[2:0], cfg_r[4:3]);
  wire ana_mode = cfg_r[`SDRC_CFG_ANA_START];
  wire [2:0] pol_lvl = sy2_r[4:2] ^ ~cfg_r[2:0];
  wire safety = safe_r | pol_lvl[1] | (|err_r);

  // analogue setpoint: 1 V per 10000 rpm and min-to-max settings both pass the setpoint unscaled
  function [15:0] scale;
    input [15:0] raw;
    input minmax;
    begin
      if (minmax)
        scale = raw[15:0];
      else
        scale = raw;
    end
  endfunction

  // key mode machine with long-press and inactivity counters
  reg [2:0] st_r;
  reg [31:0] hold_r;
  reg [31:0] idle_r;
  reg [3:0] place_r;
  reg dir_sel_r;
  reg dir_loaded_r;
  reg [2:0] src_r;
  wire stopped = (src_r == SRC_NONE);
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= ST_OPER;
      hold_r <= 32'h0;
      idle_r <= 32'h0;
      place_r <= 4'h0;
      dir_sel_r <= 1'b0;
      dir_loaded_r <= 1'b0;
      o_dir_nv_wr <= 1'b0;
      o_dir_nv_val <= 1'b0;
    end else begin
      o_dir_nv_wr <= 1'b0;
      if (!dir_loaded_r) begin
        dir_sel_r <= i_dir_nv;
        dir_loaded_r <= 1'b1;
      end
      if (key_r != key_d_r || key_r == 2'h0)
        hold_r <= 32'h0;
      else if (hold_r < HOLD_CYC)
        hold_r <= hold_r + 32'h1;
      case (st_r)
        ST_OPER: begin
          idle_r <= 32'h0;
          if (hold_r == HOLD_CYC - 1 && key_r == 2'h3) begin
            st_r <= ST_CHAR;
          end else if (hold_r == HOLD_CYC - 1 && key_r == 2'h2 && stopped)
            st_r <= ST_DIR;
        end
        ST_DIR: begin
          if (any_press) begin
            dir_sel_r <= ~dir_sel_r;
            o_dir_nv_wr <= 1'b1;
            o_dir_nv_val <= ~dir_sel_r;
          end
          if (any_press || key_r != 2'h0)
            idle_r <= 32'h0;
          else if (idle_r >= IDLE_CYC - 1)
            st_r <= ST_OPER;
          else
            idle_r <= idle_r + 32'h1;
        end
        ST_CHAR: begin
          if (start_press && place_r != NPLACE - 1)
            place_r <= place_r + 4'h1;
          else if (stop_press && place_r != 4'h0)
            place_r <= place_r - 4'h1;
          if (any_press || key_r != 2'h0)
            idle_r <= 32'h0;
          else if (idle_r >= IDLE_CYC - 1)
            st_r <= ST_OPER;
          else
            idle_r <= idle_r + 32'h1;
        end
        default: st_r <= ST_OPER;
      endcase
    end
  end

  // run arbitration: starter owns the stop, safety overrides
  wire oper = (st_r == ST_OPER);
  wire dig_on_d;
  reg dig_d_r;
  assign dig_on_d = dig_d_r;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_r <= SRC_NONE;
      dig_d_r <= 1'b0;
      o_run <= 1'b0;
      o_dir_ccw <= 1'b0;
      o_speed_cmd <= 16'h0000;
    end else begin
      dig_d_r <= dig_on;
      o_speed_cmd <= ana_mode ? scale(setp_r, cfg_r[`SDRC_CFG_MINMAX])
                              : setp_r;
      if (safety)
        src_r <= SRC_NONE;
      else case (src_r)
        SRC_NONE: begin
          if (ana_mode) begin
            if (dig_on && setp_r != 16'h0000)
              src_r <= SRC_ANA;
          end else if (setp_r != 16'h0000) begin
            if (oper && start_press && key_r != 2'h3)
              src_r <= SRC_PANEL;
            else if (dig_on && !dig_on_d)
              src_r <= SRC_DIG;
            else if (ser_start_r)
              src_r <= SRC_SER;
          end
        end
        SRC_PANEL:
          if (oper && stop_press && key_r == 2'h2)
            src_r <= SRC_NONE;
        SRC_DIG:
          if (!dig_on)
            src_r <= SRC_NONE;
        SRC_ANA:
          if (!dig_on || setp_r == 16'h0000)
            src_r <= SRC_NONE;
        SRC_SER:
          if (ser_stop_r)
            src_r <= SRC_NONE;
        default: src_r <= SRC_NONE;
      endcase
      o_run <= ~stopped & ~safety;
      if (stopped)
        o_dir_ccw <= dir_sel_r;
    end
  end

  // error rotation: step through active shutdown errors
  reg [3:0] err_idx_r;
  reg [31:0] rot_r;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      err_idx_r <= 4'h0;
      rot_r <= 32'h0;
    end else if (err_r == 16'h0000 || !err_r[err_idx_r] ||
                 rot_r >= ROT_CYC - 1) begin
      err_idx_r <= err_idx_r + 4'h1;
      rot_r <= 32'h0;
    end else
      rot_r <= rot_r + 32'h1;
  end

  // binary to two bcd digits
  function [7:0] bcd2;
    input [6:0] v;
    reg [6:0] tens;
    reg [6:0] ones;
    begin
      tens = v / 7'd10;
      ones = v % 7'd10;
      bcd2 = {tens[3:0], ones[3:0]};
    end
  endfunction

  // display, relays and leds
  wire [6:0] ecode = {3'b000, err_idx_r} + 7'd30;
  wire [9:0] spd_h = speed_r[15:6];
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_disp <= 12'h000;
      o_disp_err <= 1'b0;
      o_relay1 <= 1'b0;
      o_relay2 <= 1'b0;
      o_relay3 <= 1'b0;
      o_led_over <= 1'b0;
    end else begin
      o_relay1 <= at_speed_r & ~stopped;
      o_relay2 <= ~overload_r;
      o_relay3 <= ~(|err_r);
      o_led_over <= (|err_r) | overload_r;
      if (st_r == ST_CHAR) begin
        o_disp_err <= ~chval_r[place_r];
        o_disp <= {chval_r[place_r] ? 4'h0 : 4'hE,
                   bcd2({3'b000, place_r} + 7'd1)};
      end else if (st_r == ST_DIR) begin
        o_disp_err <= 1'b0;
        o_disp <= {8'h00, 3'b000, dir_sel_r};
      end else if (|err_r && err_r[err_idx_r]) begin
        o_disp_err <= 1'b1;
        o_disp <= {4'hE, bcd2(ecode)};
      end else if (|err_r) begin
        o_disp_err <= o_disp_err; // keep flag in step with held digits
      end else begin
        o_disp_err <= 1'b0;
        o_disp <= {spd_h[9:8] == 2'h0 ? 4'h0 : 4'h1, spd_h[7:0]};
      end
    end
  end

  // ahb-lite slave, zero wait states
  reg ph_wr_r;
  reg ph_rd_r;
  reg [7:0] ph_addr_r;
  wire take = i_hsel & i_hready & i_htrans[1];
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h0;
      cfg_r <= `SDRC_CFG_RESET;
      setp_r <= 16'h0000;
      speed_r <= 16'h0000;
      err_r <= 16'h0000;
      chval_r <= 16'h0000;
      ser_start_r <= 1'b0;
      ser_stop_r <= 1'b0;
      safe_r <= 1'b0;
      at_speed_r <= 1'b0;
      overload_r <= 1'b0;
    end else begin
      ph_wr_r <= take & i_hwrite;
      ph_rd_r <= take & ~i_hwrite;
      ph_addr_r <= i_haddr[7:0];
      ser_start_r <= 1'b0;
      ser_stop_r <= 1'b0;
      if (ph_wr_r) begin
        case (ph_addr_r)
          `SDRC_CTRL_OFS: begin
            ser_start_r <= i_hwdata[`SDRC_CTRL_SER_START];
            ser_stop_r <= i_hwdata[`SDRC_CTRL_SER_STOP];
            safe_r <= i_hwdata[`SDRC_CTRL_SAFE_STOP];
            at_speed_r <= i_hwdata[`SDRC_CTRL_AT_SPEED];
            overload_r <= i_hwdata[`SDRC_CTRL_OVERLOAD];
          end
          `SDRC_CFG_OFS: cfg_r <= {24'h0, i_hwdata[7:0]};
          `SDRC_SETP_OFS: setp_r <= i_hwdata[15:0];
          `SDRC_SPEED_OFS: speed_r <= i_hwdata[15:0];
          `SDRC_ERR_OFS: err_r <= i_hwdata[15:0];
          `SDRC_CHVAL_OFS: chval_r <= i_hwdata[15:0];
          default: ;
        endcase
      end
      if (take && !i_hwrite) begin
        case (i_haddr[7:0])
          `SDRC_CFG_OFS: o_hrdata <= cfg_r;
          `SDRC_SETP_OFS: o_hrdata <= {16'h0, setp_r};
          `SDRC_SPEED_OFS: o_hrdata <= {16'h0, speed_r};
          `SDRC_ERR_OFS: o_hrdata <= {16'h0, err_r};
          `SDRC_CHVAL_OFS: o_hrdata <= {16'h0, chval_r};
          `SDRC_STAT_OFS: o_hrdata <= {16'h0, place_r, 3'h0, dir_sel_r,
                                        st_r, o_run, src_r, 1'b0};
          `SDRC_DISP_OFS: o_hrdata <= {19'h0, o_disp_err, o_disp};
          default: o_hrdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// File: sim/sdrc_panel_model.sv
// operator panel keys and plc digital lines
`timescale 1ns/1ps
module sdrc_panel_model (
  input wire i_clk,
  output logic o_key_start,
  output logic o_key_stop,
  output logic [2:0] o_din
);
  // keys released, low-true lines idle high
  initial begin
    o_key_start = 1'b0;
    o_key_stop = 1'b0;
    o_din = 3'b111;
  end
  // keys held unbroken for n cycles, then a released gap
  task press(input logic s, input logic p, input int n);
    o_key_start <= s;
    o_key_stop <= p;
    repeat (n) @(posedge i_clk);
    o_key_start <= 1'b0;
    o_key_stop <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
  // plc line levels
  task set_din(input logic [2:0] v);
    o_din <= v;
  endtask
endmodule

// File: sim/sdrc_run_control_assertions.sv
// output assertions of the run control
`timescale 1ns/1ps
module sdrc_run_control_chk (
  input wire i_clk,
  input wire i_resetn,
  input wire o_run,
  input wire o_dir_ccw,
  input wire o_dir_nv_wr,
  input wire o_relay1,
  input wire o_relay2,
  input wire o_relay3,
  input wire o_led_over,
  input wire [11:0] o_disp,
  input wire o_disp_err
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // relays and lamp agree on faults
  a_relay3_err: assert property ($fell(o_relay3) |-> o_led_over)
    else $error("relay3 opened without lamp");
  a_relay2_ovl: assert property ($fell(o_relay2) |-> o_led_over)
    else $error("relay2 opened without lamp");
  a_lamp_cause: assert property (o_led_over && $past(o_led_over)
    |-> !o_relay3 || !o_relay2)
    else $error("lamp lit without open relay");
  // direction store pulse, direction hold, relay1, start and error digit
  a_nv_pulse: assert property (o_dir_nv_wr |=> !o_dir_nv_wr)
    else $error("store pulse too long");
  a_nv_stopped: assert property (o_dir_nv_wr |-> !o_run)
    else $error("direction stored while running");
  a_dir_hold: assert property (o_run && $past(o_run)
    |-> $stable(o_dir_ccw))
    else $error("direction changed while running");
  a_relay1_run: assert property (o_relay1 |-> o_run || $past(o_run))
    else $error("at speed relay while stopped");
  a_start_ok: assert property ($rose(o_run) |-> o_relay3)
    else $error("started during error");
  a_err_digit: assert property (o_disp_err |-> o_disp[11:8] == 4'hE)
    else $error("error display without E digit");
  // main scenarios reached
  c_run: cover property ($rose(o_run));
  c_store: cover property (o_dir_nv_wr);
  c_errdisp: cover property (o_disp_err && !o_relay3);
endmodule
bind sdrc_run_control sdrc_run_control_chk u_chk (.i_clk(i_clk),
  .i_resetn(i_resetn), .o_run(o_run), .o_dir_ccw(o_dir_ccw),
  .o_dir_nv_wr(o_dir_nv_wr), .o_relay1(o_relay1), .o_relay2(o_relay2),
  .o_relay3(o_relay3), .o_led_over(o_led_over), .o_disp(o_disp),
  .o_disp_err(o_disp_err));

// File: sim/sdrc_run_control_test.sv
// self-checking bench of the run control
`timescale 1ns/1ps
`include "sdrc_regs.vh"
module sdrc_run_control_test;
  logic i_clk, i_resetn, i_hwrite, i_hsel, i_dir_nv;
  logic [31:0] i_haddr, i_hwdata, rd;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  wire [31:0] hrdata;
  wire rdy, hresp, ks, kp, nv_wr, nv_val, run, ccw, r1, r2, r3, led, derr;
  wire [2:0] din;
  wire [15:0] spd;
  wire [11:0] disp;
  int fail_count, check_count;
  sdrc_panel_model panel (.i_clk(i_clk), .o_key_start(ks), .o_key_stop(kp),
    .o_din(din));
  sdrc_run_control #(.HOLD_CYC(20), .IDLE_CYC(40), .DEB_CYC(2), .ROT_CYC(8))
  DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hsel(i_hsel), .i_hready(rdy), .o_hrdata(hrdata),
    .o_hreadyout(rdy), .o_hresp(hresp), .i_key_start(ks), .i_key_stop(kp),
    .i_din(din), .i_dir_nv(i_dir_nv), .o_dir_nv_wr(nv_wr),
    .o_dir_nv_val(nv_val), .o_run(run), .o_dir_ccw(ccw), .o_speed_cmd(spd),
    .o_relay1(r1), .o_relay2(r2), .o_relay3(r3), .o_led_over(led),
    .o_disp(disp), .o_disp_err(derr));
  // verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task bound(input int n);
    if (n >= 60) begin
      fail_count++;
      final_report;
    end
  endtask
  // one edge with ready sampled high
  task hrdy;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rdy !== 1'b1 && n < 60);
    bound(n);
  endtask
  // single word transfer, read data kept in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_haddr <= {24'h0, a};
    i_htrans <= 2'b10;
    i_hwrite <= w;
    i_hsel <= 1'b1;
    i_hsize <= 3'b010;
    hrdy;
    i_htrans <= 2'b00;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    hrdy;
    rd = hrdata;
  endtask
  task wait_run(input logic v);
    int n;
    n = 0;
    while (run !== v && n < 60) begin
      @(posedge i_clk);
      n++;
    end
    bound(n);
    chk("run", run, v);
  endtask
  task watch_nv(input logic e);
    int n;
    n = 0;
    while (nv_wr !== 1'b1 && n < 60) begin
      @(posedge i_clk);
      n++;
    end
    bound(n);
    chk("nv_val", nv_val, e);
    tick(2);
    chk("dir", ccw, e);
  endtask
  task t_reset;
    tick(2);
    bus(1'b0, `SDRC_CFG_OFS, 32'h0);
    chk("cfg", rd, `SDRC_CFG_RESET);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", hresp, 1'b0);
    chk("dir", ccw, 1'b1);
    chk("relay3", r3, 1'b1);
    $display("test reset done");
  endtask
  task t_panel;
    panel.press(1'b1, 1'b0, 6);
    chk("run", run, 1'b0);
    bus(1'b1, `SDRC_SETP_OFS, 32'h0000_03E8);
    panel.press(1'b1, 1'b0, 1);
    chk("run", run, 1'b0);
    panel.press(1'b1, 1'b0, 6);
    wait_run(1'b1);
    panel.press(1'b0, 1'b1, 6);
    wait_run(1'b0);
    $display("test panel done");
  endtask
  task t_dir;
    panel.press(1'b0, 1'b1, 30);
    fork
      panel.press(1'b1, 1'b0, 6);
      watch_nv(1'b0);
    join
    fork
      panel.press(1'b0, 1'b1, 6);
      watch_nv(1'b1);
    join
    tick(50);
    panel.press(1'b1, 1'b0, 6);
    wait_run(1'b1);
    panel.press(1'b0, 1'b1, 6);
    wait_run(1'b0);
    $display("test direction done");
  endtask
  task t_sel;
    bus(1'b1, `SDRC_CHVAL_OFS, 32'h1);
    panel.press(1'b1, 1'b1, 30);
    chk("disp", disp, 12'h001);
    panel.press(1'b1, 1'b0, 6);
    chk("disp", disp, 12'hE02);
    chk("derr", derr, 1'b1);
    panel.press(1'b0, 1'b1, 6);
    panel.press(1'b0, 1'b1, 6);
    chk("disp", disp, 12'h001);
    chk("derr", derr, 1'b0);
    tick(50);
    $display("test select done");
  endtask
  task t_own;
    bus(1'b1, `SDRC_CTRL_OFS, 32'h1);
    wait_run(1'b1);
    panel.press(1'b0, 1'b1, 6);
    chk("run", run, 1'b1);
    bus(1'b1, `SDRC_CTRL_OFS, 32'h8);
    tick(4);
    chk("relay1", r1, 1'b1);
    bus(1'b1, `SDRC_CTRL_OFS, 32'h18);
    tick(4);
    chk("relay2", r2, 1'b0);
    chk("led", led, 1'b1);
    bus(1'b1, `SDRC_CTRL_OFS, 32'h4);
    wait_run(1'b0);
    bus(1'b1, `SDRC_CTRL_OFS, 32'h1);
    wait_run(1'b1);
    bus(1'b1, `SDRC_CTRL_OFS, 32'h2);
    wait_run(1'b0);
    $display("test owner done");
  endtask
  task t_err;
    logic s0, s1;
    s0 = 1'b0;
    s1 = 1'b0;
    bus(1'b1, `SDRC_ERR_OFS, 32'h3);
    repeat (40) begin
      @(posedge i_clk);
      if (disp === 12'hE30) s0 = 1'b1;
      if (disp === 12'hE31) s1 = 1'b1;
    end
    chk("e30", s0, 1'b1);
    chk("e31", s1, 1'b1);
    chk("relay3", r3, 1'b0);
    chk("led", led, 1'b1);
    bus(1'b1, `SDRC_ERR_OFS, 32'h0);
    tick(4);
    chk("relay3", r3, 1'b1);
    $display("test errors done");
  endtask
  task t_rem;
    panel.set_din(3'b110);
    wait_run(1'b1);
    panel.set_din(3'b100);
    wait_run(1'b0);
    panel.set_din(3'b111);
    tick(10);
    bus(1'b1, `SDRC_CFG_OFS, 32'h1);
    wait_run(1'b1);
    panel.set_din(3'b110);
    wait_run(1'b0);
    bus(1'b1, `SDRC_CFG_OFS, 32'h21);
    panel.set_din(3'b111);
    wait_run(1'b1);
    chk("speed", spd, 32'h0000_03E8);
    bus(1'b1, `SDRC_SETP_OFS, 32'h0);
    wait_run(1'b0);
    $display("test remote done");
  endtask
  task t_rst2;
    i_dir_nv <= 1'b0;
    i_resetn <= 1'b0;
    tick(3);
    i_resetn <= 1'b1;
    tick(3);
    chk("dir", ccw, 1'b0);
    chk("run", run, 1'b0);
    $display("test second reset done");
  endtask
  // clock of 5 ns
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // reset, then the scenarios in turn
  initial begin
    i_resetn = 1'b0;
    i_haddr = 32'h0;
    i_htrans = 2'b00;
    i_hwrite = 1'b0;
    i_hsel = 1'b0;
    i_hsize = 3'b010;
    i_hwdata = 32'h0;
    i_dir_nv = 1'b1;
    fail_count = 0;
    check_count = 0;
    tick(3);
    chk("rdyout", rdy, 1'b1);
    chk("run", run, 1'b0);
    i_resetn <= 1'b1;
    t_reset;
    t_panel;
    t_dir;
    t_sel;
    t_own;
    t_err;
    t_rem;
    t_rst2;
    final_report;
  end
endmodule
